// file: input_monitor_pkg.sv
// Constants and types shared by the dual-channel safety input monitor.
package input_monitor_pkg;

    // Clock and millisecond tick timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 16;

    // Window timer width in milliseconds, enough for three seconds.
    localparam int WIN_W = 12;
    localparam int MS_PER_S = 1000;
    localparam int SIM_CH_S = 3;
    localparam int PAIR_MS = 400;
    localparam int PAIR_2H_MS = 150;
    localparam int CONC_PAIR_S = 3;
    localparam logic [WIN_W-1:0] WIN_CH_MS = WIN_W'(SIM_CH_S * MS_PER_S);
    // Half a second between channels for two-hand control.
    localparam logic [WIN_W-1:0] WIN_CH_2H_MS = WIN_W'(MS_PER_S / 2);
    localparam logic [WIN_W-1:0] WIN_PAIR_MS = WIN_W'(PAIR_MS);
    localparam logic [WIN_W-1:0] WIN_PAIR_2H_MS = WIN_W'(PAIR_2H_MS);
    localparam logic [WIN_W-1:0] WIN_PAIR_CONC_MS =
        WIN_W'(CONC_PAIR_S * MS_PER_S);

    // Debounce ranges in milliseconds.
    localparam int DEB_W = 9;
    localparam logic [DEB_W-1:0] C2O_MIN_MS = 9'h006;
    localparam logic [DEB_W-1:0] C2O_MAX_MS = 9'h064;
    localparam logic [DEB_W-1:0] C2O_DEF_MS = 9'h006;
    localparam logic [DEB_W-1:0] O2C_MIN_MS = 9'h00a;
    localparam logic [DEB_W-1:0] O2C_MAX_MS = 9'h1f4;
    localparam logic [DEB_W-1:0] O2C_DEF_MS = 9'h032;

    // Input terminals and logical lines.
    localparam int N_LINES = 4;
    localparam int SEL_W = 2;

    // Circuit types handled by the monitor.
    typedef enum logic [1:0] {
        CIRC_DUAL,
        CIRC_COMPL,
        CIRC_DOUBLE,
        CIRC_MAT
    } circuit_t;

endpackage

// file: line_bus_if.sv
// Carrier for debounced input lines and the millisecond tick.
`timescale 1ns/10ps
`default_nettype none
interface line_bus_if;
    import input_monitor_pkg::*;

    logic [N_LINES-1:0] level; // Debounced logical line levels.
    logic ms_tick; // One-cycle pulse every millisecond.

    modport filter (output level, input ms_tick);
    modport monitor (input level, output ms_tick);
endinterface
`default_nettype wire

// file: line_debounce.sv
// Terminal routing and per-line debounce filter.
`timescale 1ns/10ps
`default_nettype none
module line_debounce
    import input_monitor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [N_LINES-1:0] term_in,
    input wire logic [N_LINES*SEL_W-1:0] term_map,
    input wire logic [DEB_W-1:0] c2o_ms,
    input wire logic [DEB_W-1:0] o2c_ms,
    line_bus_if.filter lines
);

    // Configured times are clamped so an out-of-range value stays safe.
    logic [DEB_W-1:0] c2o_lim; // Effective closed-to-open time.
    logic [DEB_W-1:0] o2c_lim; // Effective open-to-closed time.

    // Clamp the configured debounce times into their legal ranges.
    always_comb begin
        if (c2o_ms < C2O_MIN_MS) begin
            c2o_lim = C2O_MIN_MS; // see RULE_14
        end else if (c2o_ms > C2O_MAX_MS) begin
            c2o_lim = C2O_MAX_MS;
        end else begin
            c2o_lim = c2o_ms;
        end
        if (o2c_ms < O2C_MIN_MS) begin
            o2c_lim = O2C_MIN_MS; // see RULE_15
        end else if (o2c_ms > O2C_MAX_MS) begin
            o2c_lim = O2C_MAX_MS;
        end else begin
            o2c_lim = o2c_ms;
        end
    end

    // A net gathers the per-line levels, so each bit has its own driver.
    wire logic [N_LINES-1:0] lvl_all;

    genvar g;
    generate
        for (g = 0; g < N_LINES; g++) begin : gen_line
            logic raw; // Terminal routed to this logical line.
            logic lvl_q, lvl_d; // Accepted level.
            logic [DEB_W-1:0] cnt_q, cnt_d; // Milliseconds of disagreement.
            logic [DEB_W-1:0] lim; // Time needed for the pending edge.

            // Route the assigned terminal and count a steady new level.
            always_comb begin
                raw = term_in[term_map[g*SEL_W +: SEL_W]]; // see RULE_12
                // A falling edge is closed-to-open, a rising one the reverse.
                lim = lvl_q ? c2o_lim : o2c_lim; // see RULE_14, RULE_15
                lvl_d = lvl_q;
                cnt_d = cnt_q;
                if (raw == lvl_q) begin
                    // Any bounce back restarts the whole debounce time.
                    cnt_d = '0;
                end else if (lines.ms_tick) begin
                    if (cnt_q + 9'h001 >= lim) begin
                        lvl_d = raw;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 9'h001;
                    end
                end
            end

            // Register the line state; lines start low, which reads as Stop for dual and mat circuits only.
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    lvl_q <= 1'b0;
                    cnt_q <= '0;
                end else begin
                    lvl_q <= lvl_d;
                    cnt_q <= cnt_d;
                end
            end

            assign lvl_all[g] = lvl_q;
        end
    endgenerate

    // Hand the accepted levels to the monitor as one word.
    assign lines.level = lvl_all;

endmodule
`default_nettype wire

// file: safety_input_monitor.sv
// Dual-channel safety input monitor deciding safety output permission.
// Operation
// RULE_01 - Either channel Stop stops dual inputs.
// RULE_02 - Simultaneous dual: both Run within 3 s.
// RULE_03 - Concurrent dual: both Stop, then Run untimed.
// RULE_04 - Doubled input stops on any Stop pair.
// RULE_05 - Simultaneous doubled: contacts within 400/150 ms.
// RULE_06 - Simultaneous doubled: channels within 3/0.5 s.
// RULE_07 - Concurrent doubled: contacts within 3 s only.
// RULE_08 - Mat Stop on short, open, wrong level.
// RULE_09 - Manual reset holds outputs off until reset.
// RULE_10 - Automatic reset resumes when all inputs Run.
// RULE_11 - Transition rule selectable where type permits.
// RULE_12 - Terminal assignment changeable, monitoring follows it.
// RULE_13 - Output on only while all controlling inputs Run.
// RULE_14 - Closed-to-open debounce 6..100 ms, default 6.
// RULE_15 - Open-to-closed debounce 10..500 ms, default 50.
// RULE_16 - Windows timed by millisecond tick from clock.
// RULE_17 - Expired window faults until both channels Stop.
`timescale 1ns/10ps
`default_nettype none
module safety_input_monitor
    import input_monitor_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [N_LINES-1:0] term_in,
    input wire logic [N_LINES*SEL_W-1:0] term_map,
    input wire logic [1:0] circuit_type,
    input wire logic input_transition_rule,
    input wire logic two_hand,
    input wire logic manual_reset_mode,
    input wire logic reset_request,
    input wire logic others_run,
    input wire logic [DEB_W-1:0] c2o_ms,
    input wire logic [DEB_W-1:0] o2c_ms,
    output logic safety_out_on,
    output logic input_run,
    output logic input_fault
);

    typedef enum logic [1:0] {
        ST_WAIT_STOP,
        ST_ARMED,
        ST_RUN,
        ST_FAULT
    } mon_state_t;

    line_bus_if lines ();

    // Terminal routing and debounce sit in their own module.
    line_debounce u_debounce (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .term_in (term_in),
        .term_map (term_map),
        .c2o_ms (c2o_ms),
        .o2c_ms (o2c_ms),
        .lines (lines)
    );

    // Advance a window timer: hold at zero until started, then count ticks.
    function automatic logic [WIN_W-1:0] win_next(
        input logic [WIN_W-1:0] cnt,
        input logic started,
        input logic tick
    );
        logic [WIN_W-1:0] nxt;
        nxt = cnt;
        if (!started) begin
            nxt = '0;
        end else if (tick && cnt != {WIN_W{1'b1}}) begin
            nxt = cnt + 12'h001;
        end
        return nxt;
    endfunction

    logic [TICK_W-1:0] div_q, div_d; // Millisecond divider.
    logic tick; // One-cycle millisecond pulse.

    // Derive the millisecond tick from the system clock.
    always_comb begin
        tick = (div_q == TICK_W'(TICK_CYCLES - 1)); // see RULE_16
        div_d = tick ? '0 : div_q + 16'h0001;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    assign lines.ms_tick = tick;

    circuit_t circ; // Configured circuit type.
    logic conc; // Effective concurrent checking.
    logic a0, a1, b0, b1; // Debounced lines; only b1 is inverted to its Run sense.
    logic a_run, b_run; // Channel fully in Run.
    logic a_any, b_any; // Channel has started toward Run.
    logic both_run, all_stop;

    // Decode the debounced lines into contact and channel Run states.
    always_comb begin
        circ = circuit_t'(circuit_type);
        // Two-hand control only allows simultaneous checking.
        conc = input_transition_rule && !two_hand; // see RULE_11
        a0 = lines.level[0];
        a1 = lines.level[1];
        b0 = lines.level[2];
        b1 = !lines.level[3];
        a_run = a0;
        b_run = a1;
        a_any = a_run;
        b_any = b_run;
        case (circ)
            CIRC_DUAL: begin
                a_run = a0; // see RULE_01
                b_run = a1;
            end
            CIRC_COMPL: begin
                // Second channel is Run while low.
                a_run = a0; // see RULE_01
                b_run = !a1;
            end
            CIRC_DOUBLE: begin
                // Pair A is lines 0/1, pair B lines 2/3, second of each low.
                a_run = a0 && !a1; // see RULE_04
                b_run = b0 && b1;
                a_any = a0 || !a1;
                b_any = b0 || b1;
            end
            CIRC_MAT: begin
                // Run needs line 0 low and line 1 high; a short, open wire
                // or either wrong level reads as Stop.
                a_run = !a0 && a1; // see RULE_08
                b_run = a_run;
            end
            default: begin
                a_run = 1'b0;
                b_run = 1'b0;
            end
        endcase
        if (circ != CIRC_DOUBLE) begin
            a_any = a_run;
            b_any = b_run;
        end
        both_run = a_run && b_run;
        all_stop = !a_any && !b_any;
    end

    mon_state_t st_q, st_d;
    logic [WIN_W-1:0] t_ch_q, t_ch_d; // Between-channel window.
    logic [WIN_W-1:0] t_a_q, t_a_d; // Within channel A window.
    logic [WIN_W-1:0] t_b_q, t_b_d; // Within channel B window.
    logic [WIN_W-1:0] lim_ch, lim_pair;
    logic ch_late, pair_late;
    logic latch_q, latch_d; // Manual reset still owed.
    logic out_q, out_d;

    // Window checking and the Stop/Run sequence.
    always_comb begin
        lim_ch = two_hand ? WIN_CH_2H_MS : WIN_CH_MS; // see RULE_06
        lim_pair = two_hand ? WIN_PAIR_2H_MS : WIN_PAIR_MS; // see RULE_05
        if (conc) begin
            lim_pair = WIN_PAIR_CONC_MS; // see RULE_07
        end
        // Counting restarts with the first transition toward Run.
        t_ch_d = win_next(t_ch_q, st_q == ST_ARMED && (a_any || b_any),
                          tick); // see RULE_16
        t_a_d = win_next(t_a_q, st_q == ST_ARMED && a_any, tick);
        t_b_d = win_next(t_b_q, st_q == ST_ARMED && b_any, tick);
        // Concurrent and mat circuits have no channel simultaneity.
        ch_late = !conc && circ != CIRC_MAT && !both_run &&
                  t_ch_q >= lim_ch; // see RULE_02, RULE_06
        pair_late = circ == CIRC_DOUBLE &&
                    ((!a_run && t_a_q >= lim_pair) ||
                     (!b_run && t_b_q >= lim_pair)); // see RULE_05, RULE_07
        st_d = st_q;
        case (st_q)
            ST_WAIT_STOP: begin
                // Both channels must be seen in Stop before arming.
                if (all_stop) begin
                    st_d = ST_ARMED; // see RULE_02, RULE_03
                end
            end
            ST_ARMED: begin
                if (ch_late || pair_late) begin
                    st_d = ST_FAULT; // see RULE_17
                end else if (both_run) begin
                    st_d = ST_RUN; // see RULE_03
                end
            end
            ST_RUN: begin
                // Any channel or contact pair in Stop ends Run at once.
                if (!both_run) begin
                    st_d = ST_WAIT_STOP; // see RULE_01, RULE_04
                end
            end
            ST_FAULT: begin
                if (all_stop) begin
                    st_d = ST_ARMED; // see RULE_17
                end
            end
            default: begin
                st_d = ST_WAIT_STOP;
            end
        endcase
    end

    // Manual reset latch and the output decision.
    always_comb begin
        latch_d = latch_q;
        if (!manual_reset_mode) begin
            latch_d = 1'b0; // see RULE_10
        end else if (st_q != ST_RUN) begin
            latch_d = 1'b1; // see RULE_09
        end else if (reset_request) begin
            // A reset only counts while the input is back in Run.
            latch_d = 1'b0; // see RULE_09
        end
        out_d = st_q == ST_RUN && both_run && !latch_q &&
                others_run; // see RULE_10, RULE_13
    end

    // Register the sequence, timers, latch and output.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_q <= ST_WAIT_STOP;
            t_ch_q <= '0;
            t_a_q <= '0;
            t_b_q <= '0;
            latch_q <= 1'b1;
            out_q <= 1'b0;
        end else begin
            st_q <= st_d;
            t_ch_q <= t_ch_d;
            t_a_q <= t_a_d;
            t_b_q <= t_b_d;
            latch_q <= latch_d;
            out_q <= out_d;
        end
    end

    assign safety_out_on = out_q;
    assign input_run = st_q == ST_RUN;
    assign input_fault = st_q == ST_FAULT;

endmodule
`default_nettype wire

// file: safety_input_monitor_chk.sv
// Port-level assertion checker for the safety input monitor.
`timescale 1ns/10ps
`default_nettype none
module safety_input_monitor_chk
    import input_monitor_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [N_LINES-1:0] term_in,
    input wire logic [N_LINES*SEL_W-1:0] term_map,
    input wire logic [1:0] circuit_type,
    input wire logic input_transition_rule,
    input wire logic two_hand,
    input wire logic manual_reset_mode,
    input wire logic reset_request,
    input wire logic others_run,
    input wire logic [DEB_W-1:0] c2o_ms,
    input wire logic [DEB_W-1:0] o2c_ms,
    input wire logic safety_out_on,
    input wire logic input_run,
    input wire logic input_fault
);
    // One clock domain, so clock and reset are given once for all.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Permission lags the state by one edge, hence the look back.
    AST_OUT_NEEDS_RUN:
    assert property (safety_out_on |-> $past(input_run) && $past(others_run))
        else $error("output on without run and others run");
    AST_RUN_DROP_OFF:
    assert property ($fell(input_run) |=> !safety_out_on)
        else $error("output still on after input left run");
    AST_OTHERS_OFF:
    assert property (!others_run |=> !safety_out_on)
        else $error("output on while another input is stopped");
    // The next cycle still in Run proves both channels stayed in Run.
    AST_TRIP_RESUME:
    assert property (input_run && others_run && !manual_reset_mode
        && !$past(manual_reset_mode) ##1 input_run |-> safety_out_on)
        else $error("trip mode output did not resume");
    // A rise caused by others_run returning is not a latch release.
    AST_LATCH_NEEDS_REQ:
    assert property (manual_reset_mode && $rose(safety_out_on)
        && $past(others_run, 2) |-> $past(reset_request)
        || $past(reset_request, 2) || $past(reset_request, 3))
        else $error("latched output rose without a reset request");
    AST_FAULT_OUT_OFF:
    assert property (input_fault |-> !safety_out_on)
        else $error("output on during a window fault");
    AST_FAULT_NOT_FROM_RUN:
    assert property ($rose(input_fault) |-> !$past(input_run))
        else $error("window fault raised from run");
    // A fault may only end by re-arming, never straight into Run.
    AST_FAULT_EXIT_ARMED:
    assert property ($fell(input_fault) |-> !input_run)
        else $error("window fault left straight to run");
endmodule

bind safety_input_monitor safety_input_monitor_chk #(
    .TICK_CYCLES(TICK_CYCLES)
) chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .term_in(term_in),
    .term_map(term_map), .circuit_type(circuit_type),
    .input_transition_rule(input_transition_rule), .two_hand(two_hand),
    .manual_reset_mode(manual_reset_mode), .reset_request(reset_request),
    .others_run(others_run), .c2o_ms(c2o_ms), .o2c_ms(o2c_ms),
    .safety_out_on(safety_out_on), .input_run(input_run),
    .input_fault(input_fault)
);
`default_nettype wire

// file: safety_switch_model.sv
// Model of the dual-channel switches, sensors and mats at the terminals.
`timescale 1ns/10ps
`default_nettype none
module safety_switch_model
    import input_monitor_pkg::*;
(
    input wire logic [1:0] circuit_type,
    input wire logic [3:0] run_cmd,
    input wire logic reversed,
    output logic [N_LINES-1:0] term_out
);
    logic [N_LINES-1:0] lv; // Line levels before any rewiring.

    // Each contact bit asks for Run; unused terminals sit at the pull-down.
    always_comb begin
        lv = 4'h0;
        case (circuit_t'(circuit_type))
            CIRC_DUAL: lv = {2'b00, run_cmd[1], run_cmd[0]};
            CIRC_COMPL: lv = {2'b00, ~run_cmd[1], run_cmd[0]};
            CIRC_DOUBLE: lv = {~run_cmd[3], run_cmd[2],
                               ~run_cmd[1], run_cmd[0]};
            // Mat: 01 reads open, 10 reads shorted, 11 is the healthy mat.
            default: lv = {2'b00, run_cmd[1], ~run_cmd[0]};
        endcase
        // Reversed wiring lets the bench move lines to other terminals.
        term_out = reversed ? {lv[0], lv[1], lv[2], lv[3]} : lv;
    end
endmodule
`default_nettype wire

// file: safety_input_monitor_tb.sv
// Self-checking testbench for the safety input monitor.
`timescale 1ns/10ps
`default_nettype none
module safety_input_monitor_tb;
    import input_monitor_pkg::*;
    localparam int TK = 2; // Short millisecond tick keeps the run brief.
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [N_LINES-1:0] term_in;
    logic [7:0] term_map = 8'he4; // Line g on terminal g.
    logic [1:0] circuit_type = 2'h0;
    logic input_transition_rule = 1'b0;
    logic two_hand = 1'b0;
    logic manual_reset_mode = 1'b0;
    logic reset_request = 1'b0;
    logic others_run = 1'b1;
    logic [DEB_W-1:0] c2o_ms = 9'h006; // Closed-to-open debounce setting.
    logic [DEB_W-1:0] o2c_ms = 9'h00a; // Open-to-closed debounce setting.
    logic [3:0] run_cmd = 4'h0; // Contact Run requests a1, a2, b1, b2.
    logic reversed = 1'b0;
    logic safety_out_on, input_run, input_fault;
    int n_errors = 0;
    int num_checks = 0;

    safety_switch_model sw (.circuit_type(circuit_type), .run_cmd(run_cmd),
        .reversed(reversed), .term_out(term_in));
    safety_input_monitor #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk),
        .reset_n(reset_n), .term_in(term_in), .term_map(term_map),
        .circuit_type(circuit_type), .two_hand(two_hand),
        .input_transition_rule(input_transition_rule),
        .manual_reset_mode(manual_reset_mode),
        .reset_request(reset_request), .others_run(others_run),
        .c2o_ms(c2o_ms), .o2c_ms(o2c_ms), .safety_out_on(safety_out_on),
        .input_run(input_run), .input_fault(input_fault));

    // Free-running 40 MHz clock.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Compares one settled output bit and counts the result.
    task automatic check(input logic got, input logic want);
        num_checks++;
        if (got !== want) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Arms from all-Stop, raises contacts s1, waits gap ms, raises the rest.
    task automatic attempt(input logic [1:0] ct, input logic tr, th,
            input logic [3:0] s1, input int gap, input logic ok, fl);
        @(posedge ref_clk);
        circuit_type <= ct;
        input_transition_rule <= tr;
        two_hand <= th;
        run_cmd <= 4'h0;
        wait_cyc(100);
        @(negedge ref_clk);
        check(input_fault, 1'b0);
        @(posedge ref_clk);
        run_cmd <= s1;
        // One extra cycle keeps a zero gap from writing run_cmd twice.
        wait_cyc(gap * TK + 1);
        run_cmd <= 4'hf;
        wait_cyc(100);
        @(negedge ref_clk);
        check(input_run, ok);
        check(input_fault, fl);
        check(safety_out_on, ok & ~manual_reset_mode);
    endtask

    // From Run, drops the contacts cleared in cmd and expects outputs off.
    task automatic drop(input logic [3:0] cmd);
        @(posedge ref_clk);
        run_cmd <= cmd;
        wait_cyc(60);
        @(negedge ref_clk);
        check(input_run, 1'b0);
        check(safety_out_on, 1'b0);
    endtask

    task automatic conclude;
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog sized at twice the expected run length.
    initial begin
        #2500000;
        n_errors++;
        conclude();
    end

    // Main sequence of scenarios.
    initial begin
        wait_cyc(8);
        reset_n <= 1'b1;
        attempt(2'h0, 1'b0, 1'b0, 4'h1, 2900, 1'b1, 1'b0);
        drop(4'he);
        attempt(2'h0, 1'b0, 1'b0, 4'h1, 3100, 1'b0, 1'b1);
        attempt(2'h0, 1'b1, 1'b0, 4'h1, 3100, 1'b1, 1'b0);
        @(posedge ref_clk);
        others_run <= 1'b0;
        wait_cyc(3);
        @(negedge ref_clk);
        check(safety_out_on, 1'b0);
        @(posedge ref_clk);
        others_run <= 1'b1;
        wait_cyc(3);
        @(negedge ref_clk);
        check(safety_out_on, 1'b1);
        attempt(2'h1, 1'b0, 1'b0, 4'hf, 0, 1'b1, 1'b0);
        drop(4'he);
        attempt(2'h2, 1'b0, 1'b0, 4'h1, 350, 1'b1, 1'b0);
        drop(4'hd);
        attempt(2'h2, 1'b0, 1'b0, 4'h1, 450, 1'b0, 1'b1);
        attempt(2'h2, 1'b1, 1'b1, 4'h1, 100, 1'b1, 1'b0);
        attempt(2'h2, 1'b0, 1'b1, 4'h1, 200, 1'b0, 1'b1);
        attempt(2'h2, 1'b0, 1'b0, 4'h3, 3100, 1'b0, 1'b1);
        attempt(2'h2, 1'b0, 1'b1, 4'h3, 400, 1'b1, 1'b0);
        attempt(2'h2, 1'b0, 1'b1, 4'h3, 600, 1'b0, 1'b1);
        attempt(2'h2, 1'b1, 1'b0, 4'h1, 3100, 1'b0, 1'b1);
        attempt(2'h2, 1'b1, 1'b0, 4'h3, 3500, 1'b1, 1'b0);
        attempt(2'h3, 1'b0, 1'b0, 4'hf, 0, 1'b1, 1'b0);
        drop(4'h2);
        attempt(2'h3, 1'b0, 1'b0, 4'hf, 0, 1'b1, 1'b0);
        drop(4'h1);
        @(posedge ref_clk);
        term_map <= 8'h1b;
        reversed <= 1'b1;
        attempt(2'h0, 1'b0, 1'b0, 4'hf, 0, 1'b1, 1'b0);
        @(posedge ref_clk);
        reversed <= 1'b0;
        attempt(2'h0, 1'b0, 1'b0, 4'hf, 0, 1'b0, 1'b0);
        @(posedge ref_clk);
        term_map <= 8'he4;
        manual_reset_mode <= 1'b1;
        attempt(2'h0, 1'b0, 1'b0, 4'hf, 0, 1'b1, 1'b0);
        @(posedge ref_clk);
        reset_request <= 1'b1;
        @(posedge ref_clk);
        reset_request <= 1'b0;
        wait_cyc(4);
        @(negedge ref_clk);
        check(safety_out_on, 1'b1);
        drop(4'h2);
        // Out-of-range settings clamp to a 10 ms rise and a 100 ms fall.
        @(posedge ref_clk);
        run_cmd <= 4'h0;
        o2c_ms <= 9'h000;
        wait_cyc(40);
        run_cmd <= 4'h3;
        wait_cyc(16);
        @(negedge ref_clk);
        check(input_run, 1'b0);
        wait_cyc(8);
        @(negedge ref_clk);
        check(input_run, 1'b1);
        @(posedge ref_clk);
        run_cmd <= 4'h0;
        c2o_ms <= 9'h1ff;
        wait_cyc(190);
        @(negedge ref_clk);
        check(input_run, 1'b1);
        wait_cyc(20);
        @(negedge ref_clk);
        check(input_run, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
